// file: design/ansel_defines.svh
// Register map, implemented-bit masks and reset values for the analog select block
//
// Behaviour
// - A select bit of 1 makes its pin analog and blocks the digital read; 0 makes it digital.
// - Every implemented select bit is read/write and resets to 1.
// - Unimplemented bit positions ignore writes and read as zero.
// - Port A implements select bits 10, 9, 7 and 6 only.
// - Port B implements select bits 15 down to 0.
// - Port C implements select bits 14, 13 and 4 only.
// - Port D implements select bits 7 and 6 only.
// - Port E implements select bit 9 only.
// - On the small package the port A and port E select registers are absent.
// - On the small package port C bit 4 is absent and reads zero; bits 14 and 13 remain.
// - Reading the port value returns zero for any pin configured as analog input.
// - Direction bit 1 means input, and all pins are inputs after reset.
`ifndef ANSEL_DEFINES_SVH
`define ANSEL_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_SEL_A 8'h00
`define OFS_SEL_B 8'h04
`define OFS_SEL_C 8'h08
`define OFS_SEL_D 8'h0c
`define OFS_SEL_E 8'h10
`define OFS_DIR_A 8'h20
`define OFS_DIR_B 8'h24
`define OFS_DIR_C 8'h28
`define OFS_DIR_D 8'h2c
`define OFS_DIR_E 8'h30
`define OFS_VAL_A 8'h40
`define OFS_VAL_B 8'h44
`define OFS_VAL_C 8'h48
`define OFS_VAL_D 8'h4c
`define OFS_VAL_E 8'h50

// ----------------------------------------------------------------
// Implemented select bits per port
// ----------------------------------------------------------------
`define MASK_SEL_A 16'h06c0
`define MASK_SEL_B 16'hffff
`define MASK_SEL_C 16'h6010
`define MASK_SEL_C_SMALL 16'h6000
`define MASK_SEL_D 16'h00c0
`define MASK_SEL_E 16'h0200
`define MASK_NONE 16'h0000

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_SEL 16'hffff
`define RST_DIR 16'hffff

// ----------------------------------------------------------------
// AHB-Lite encodings
// ----------------------------------------------------------------
`define HTRANS_NONSEQ 2'b10
`define HTRANS_SEQ 2'b11
`define ADDR_LSB 2
`define ADDR_MSB 7

`endif

// file: design/ansel_pkg.sv
// Types shared by the analog select block
package ansel_pkg;
	typedef logic [15:0] port_word_t;
	typedef enum logic [1:0] {
		KIND_SEL = 2'b00,
		KIND_DIR = 2'b01,
		KIND_VAL = 2'b10,
		KIND_NONE = 2'b11
	} reg_kind_e;
endpackage

// file: design/ansel_port.sv
// One port: select and direction registers plus the synchronised, gated read path
`timescale 1ns/1ps
`include "ansel_defines.svh"
module ansel_port #(
	parameter logic [15:0] SEL_MASK = `MASK_SEL_B
) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	input wire logic clk_en, // Freezes state while low
	input wire logic sel_we, // Write strobe for select register
	input wire logic dir_we, // Write strobe for direction register
	input wire ansel_pkg::port_word_t wdata, // Write data
	input wire ansel_pkg::port_word_t pin_in, // Raw pin levels
	output ansel_pkg::port_word_t sel, // Select register contents
	output ansel_pkg::port_word_t dir, // Direction register contents
	output ansel_pkg::port_word_t val // Gated pin value
);
	ansel_pkg::port_word_t sel_r, sel_nxt, dir_r, dir_nxt;
	ansel_pkg::port_word_t meta_r, sync_r;

	always_comb begin
		sel_nxt = sel_r;
		dir_nxt = dir_r;
		if (sel_we) begin
			sel_nxt = wdata & SEL_MASK;
		end
		if (dir_we) begin
			dir_nxt = wdata;
		end
	end

	// Unimplemented positions reset to zero so they never read as one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_r <= `RST_SEL & SEL_MASK;
			dir_r <= `RST_DIR;
			meta_r <= '0;
			sync_r <= '0;
		end else if (clk_en) begin
			sel_r <= sel_nxt;
			dir_r <= dir_nxt;
			meta_r <= pin_in;
			sync_r <= meta_r;
		end
	end

	assign sel = sel_r;
	assign dir = dir_r;
	// Analog pins read low; only the second sync stage feeds the gate
	assign val = sync_r & ~sel_r;
endmodule

// file: design/ansel_top.sv
// AHB-Lite slave holding the analog select and direction registers of ports A to E
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ansel_defines.svh"
module ansel_top #(
	parameter bit SMALL_PKG = 1'b0 // Small package variant
) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	input wire logic clk_en, // Freezes state while low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write
	input wire logic [2:0] hsize, // Size
	input wire logic hready, // Bus ready in
	input wire logic [31:0] hwdata, // Write data
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Always ready
	output logic hresp, // Always OKAY
	input wire logic [79:0] pin_in, // Pins of ports A..E, 16 each
	output logic [79:0] pin_is_input, // Direction bits, 1 = input
	output logic [79:0] pin_is_analog // Select bits, 1 = analog
);
	localparam int NPORT = 5;
	localparam logic [15:0] MASK_C = SMALL_PKG ? `MASK_SEL_C_SMALL : `MASK_SEL_C;
	localparam logic [15:0] MASK_A = SMALL_PKG ? `MASK_NONE : `MASK_SEL_A;
	localparam logic [15:0] MASK_E = SMALL_PKG ? `MASK_NONE : `MASK_SEL_E;
	localparam logic [NPORT*16-1:0] MASKS = {MASK_E, `MASK_SEL_D, MASK_C, `MASK_SEL_B, MASK_A};

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic ansel_pkg::reg_kind_e kind_of(input logic [7:0] a);
		case (a)
			`OFS_SEL_A, `OFS_SEL_B, `OFS_SEL_C, `OFS_SEL_D, `OFS_SEL_E: kind_of = ansel_pkg::KIND_SEL;
			`OFS_DIR_A, `OFS_DIR_B, `OFS_DIR_C, `OFS_DIR_D, `OFS_DIR_E: kind_of = ansel_pkg::KIND_DIR;
			`OFS_VAL_A, `OFS_VAL_B, `OFS_VAL_C, `OFS_VAL_D, `OFS_VAL_E: kind_of = ansel_pkg::KIND_VAL;
			default: kind_of = ansel_pkg::KIND_NONE;
		endcase
	endfunction

	function automatic logic [2:0] port_of(input logic [7:0] a);
		case (a)
			`OFS_SEL_A, `OFS_DIR_A, `OFS_VAL_A: port_of = 3'h0;
			`OFS_SEL_B, `OFS_DIR_B, `OFS_VAL_B: port_of = 3'h1;
			`OFS_SEL_C, `OFS_DIR_C, `OFS_VAL_C: port_of = 3'h2;
			`OFS_SEL_D, `OFS_DIR_D, `OFS_VAL_D: port_of = 3'h3;
			`OFS_SEL_E, `OFS_DIR_E, `OFS_VAL_E: port_of = 3'h4;
			default: port_of = 3'h7;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Address phase capture
	// ----------------------------------------------------------------
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic take;
	logic [7:0] a_now;
	ansel_pkg::port_word_t sel_w [NPORT];
	ansel_pkg::port_word_t dir_w [NPORT];
	ansel_pkg::port_word_t val_w [NPORT];

	assign take = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
	assign a_now = {haddr[`ADDR_MSB:`ADDR_LSB], 2'b00};

	// Reads are answered from the address phase so data stand in the next cycle
	always_comb begin
		wr_pend_nxt = take && hwrite;
		addr_nxt = take ? a_now : addr_r;
		rdata_nxt = rdata_r;
		if (take && !hwrite) begin
			rdata_nxt = '0;
			if (port_of(a_now) < 3'(NPORT)) begin
				case (kind_of(a_now))
					ansel_pkg::KIND_SEL: rdata_nxt = {16'h0000, sel_w[port_of(a_now)]};
					ansel_pkg::KIND_DIR: rdata_nxt = {16'h0000, dir_w[port_of(a_now)]};
					ansel_pkg::KIND_VAL: rdata_nxt = {16'h0000, val_w[port_of(a_now)]};
					default: rdata_nxt = '0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			addr_r <= 8'h00;
			rdata_r <= 32'h0000_0000;
		end else if (clk_en) begin
			wr_pend_r <= wr_pend_nxt;
			addr_r <= addr_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign hrdata = rdata_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// ----------------------------------------------------------------
	// Ports
	// ----------------------------------------------------------------
	// Writes land in the data phase; registers change at its closing edge
	genvar g;
	generate
		for (g = 0; g < NPORT; g++) begin : g_port
			logic sel_we, dir_we;
			assign sel_we = wr_pend_r && kind_of(addr_r) == ansel_pkg::KIND_SEL
				&& port_of(addr_r) == 3'(g);
			assign dir_we = wr_pend_r && kind_of(addr_r) == ansel_pkg::KIND_DIR
				&& port_of(addr_r) == 3'(g);
			ansel_port #(
				.SEL_MASK(MASKS[g*16 +: 16])
			) u_port (
				.hclk(hclk),
				.hresetn(hresetn),
				.clk_en(clk_en),
				.sel_we(sel_we),
				.dir_we(dir_we),
				.wdata(hwdata[15:0]),
				.pin_in(pin_in[g*16 +: 16]),
				.sel(sel_w[g]),
				.dir(dir_w[g]),
				.val(val_w[g])
			);
			assign pin_is_input[g*16 +: 16] = dir_w[g];
			assign pin_is_analog[g*16 +: 16] = sel_w[g];
		end
	endgenerate
endmodule

// file: test/ansel_properties.sv
// Checker for the analog select block
`timescale 1ns/1ps
`include "ansel_defines.svh"
module ansel_chk #(
	parameter bit SMALL_PKG = 1'b0 // Small package
) (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, low
	input wire logic clk_en, // Run
	input wire logic hsel, // Select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Type
	input wire logic hwrite, // Write
	input wire logic [31:0] hwdata, // Wdata
	input wire logic [31:0] hrdata, // Rdata
	input wire logic [79:0] pin_is_input, // Dirs
	input wire logic [79:0] pin_is_analog // Selects
);
localparam logic [79:0] RST = {SMALL_PKG ? 16'h0000 : `MASK_SEL_E, `MASK_SEL_D,
	SMALL_PKG ? `MASK_SEL_C_SMALL : `MASK_SEL_C, `MASK_SEL_B, SMALL_PKG ? 16'h0000 : `MASK_SEL_A};
default clocking cb @(posedge hclk); endclocking
default disable iff (!hresetn);
// ----
// Properties
// ----
property p_mask_a; (pin_is_analog[15:0] & ~RST[15:0]) == 16'h0000; endproperty
a_mask_a: assert property (p_mask_a) else $error("port a extra bit");
property p_mask_c; (pin_is_analog[47:32] & ~RST[47:32]) == 16'h0000; endproperty
a_mask_c: assert property (p_mask_c) else $error("port c extra bit");
property p_mask_d; (pin_is_analog[63:48] & ~RST[63:48]) == 16'h0000; endproperty
a_mask_d: assert property (p_mask_d) else $error("port d extra bit");
property p_mask_e; (pin_is_analog[79:64] & ~RST[79:64]) == 16'h0000; endproperty
a_mask_e: assert property (p_mask_e) else $error("port e extra bit");
property p_rst; $rose(hresetn) |-> pin_is_analog == RST && (&pin_is_input); endproperty
a_rst: assert property (p_rst) else $error("reset values");
property p_hi; hrdata[31:16] == 16'h0000; endproperty
a_hi: assert property (p_hi) else $error("upper read half");
property p_wr_b;
	hsel && htrans == `HTRANS_NONSEQ && hwrite && haddr[7:0] == `OFS_SEL_B && clk_en ##1 clk_en
	|=> pin_is_analog[31:16] == $past(hwdata[15:0]);
endproperty
a_wr_b: assert property (p_wr_b) else $error("port b select write");
property p_quiet; $changed(pin_is_analog) |-> $past(hsel && hwrite && htrans[1], 2); endproperty
a_quiet: assert property (p_quiet) else $error("select moved without write");
endmodule
bind ansel_top ansel_chk #(.SMALL_PKG(SMALL_PKG)) chk_u (.hclk(hclk), .hresetn(hresetn),
	.clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hrdata(hrdata), .pin_is_input(pin_is_input),
	.pin_is_analog(pin_is_analog));

// file: test/ansel_top_tb.sv
// Self-checking testbench for the analog select block
`timescale 1ns/1ps
`include "ansel_defines.svh"
module ansel_top_tb;
localparam logic [15:0] PAT = 16'ha5c3;
localparam logic [15:0] MSK [5] = '{`MASK_SEL_A, `MASK_SEL_B, `MASK_SEL_C, `MASK_SEL_D,
	`MASK_SEL_E};
// Small package: ports A and E have no select register, port C loses bit 4
localparam logic [15:0] MSK_S [5] = '{`MASK_NONE, `MASK_SEL_B, `MASK_SEL_C_SMALL, `MASK_SEL_D,
	`MASK_NONE};
logic hclk = 1'b0;
logic hresetn = 1'b0;
logic hsel = 1'b0;
logic [31:0] haddr = 32'h0;
logic [1:0] htrans = 2'b00;
logic hwrite = 1'b0;
logic [31:0] hwdata = 32'h0;
logic [79:0] pin_in = {5{PAT}};
logic [31:0] hrdata;
logic hreadyout;
logic hresp;
logic clk_en = 1'b1;
logic [31:0] hrdata_s;
logic [79:0] pin_is_analog_s;
logic [79:0] pin_is_input;
logic [79:0] pin_is_analog;
int errors = 0;
int checked = 0;
ansel_top dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
	.pin_is_input(pin_is_input), .pin_is_analog(pin_is_analog));
// Small package copy on the same bus; it answers in the same cycles as the main one
if (1) begin : g_small
	ansel_top #(.SMALL_PKG(1'b1)) dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata_s), .hreadyout(), .hresp(),
		.pin_in(pin_in), .pin_is_input(), .pin_is_analog(pin_is_analog_s));
end
initial begin
	forever #2 hclk = ~hclk;
end
// ----
// Tasks
// ----
task automatic stop_test();
	$display("errors %0d checked %0d", errors, checked);
	if (errors == 0 && checked > 0) begin
		$display("STATUS OK");
	end else begin
		$display("STATUS NOT OK");
	end
	$finish;
endtask
task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
	checked++;
	if (g !== e) begin
		errors++;
		$display("mismatch %s expected %h seen %h", nm, e, g);
	end
endtask
task automatic wait_rdy();
	int n;
	n = 0;
	@(posedge hclk);
	while (hreadyout !== 1'b1) begin
		n++;
		if (n > 100) begin
			errors++;
			stop_test();
		end
		@(posedge hclk);
	end
endtask
task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
	output logic [31:0] q);
	hsel <= 1'b1;
	haddr <= {24'h0, a};
	hwrite <= wr;
	htrans <= `HTRANS_NONSEQ;
	wait_rdy();
	hsel <= 1'b0;
	htrans <= 2'b00;
	hwdata <= {16'h0, d};
	wait_rdy();
	q = hrdata;
	chk("response", 16'h0000, {15'h0000, hresp});
endtask
task automatic wr(input logic [7:0] a, input logic [15:0] d);
	logic [31:0] q;
	bus(1'b1, a, d, q);
endtask
task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
	logic [31:0] q;
	bus(1'b0, a, 16'h0, q);
	chk(nm, e, q[15:0]);
	chk("upper half", 16'h0, q[31:16]);
endtask
task automatic t_reset();
	for (int i = 0; i < 5; i++) begin
		rd(8'h00 + 8'(4 * i), MSK[i], "select reset");
		chk("small select reset", MSK_S[i], hrdata_s[15:0]);
		chk("small analog pin reset", MSK_S[i], pin_is_analog_s[16 * i +: 16]);
		rd(8'h20 + 8'(4 * i), 16'hffff, "direction reset");
		rd(8'h40 + 8'(4 * i), PAT & ~MSK[i], "analog value");
	end
endtask
task automatic t_sel();
	logic [15:0] v [3] = '{16'h0000, 16'h5a5a, 16'hffff};
	for (int k = 0; k < 3; k++) begin
		for (int i = 0; i < 5; i++) begin
			wr(8'h00 + 8'(4 * i), v[k]);
			rd(8'h00 + 8'(4 * i), v[k] & MSK[i], "select");
			rd(8'h40 + 8'(4 * i), PAT & ~(v[k] & MSK[i]), "value");
			chk("small value", PAT & ~(v[k] & MSK_S[i]), hrdata_s[15:0]);
			chk("analog pin", v[k] & MSK[i], pin_is_analog[16 * i +: 16]);
			chk("small analog pin", v[k] & MSK_S[i], pin_is_analog_s[16 * i +: 16]);
		end
	end
endtask
task automatic t_dir();
	wr(8'h04, 16'h0000);
	wr(8'h24, 16'h0f0f);
	rd(8'h24, 16'h0f0f, "direction");
	chk("input pin", 16'h0f0f, pin_is_input[31:16]);
	rd(8'h44, PAT, "digital value");
endtask
task automatic t_unmapped();
	wr(8'h3c, 16'hffff);
	rd(8'h3c, 16'h0000, "unmapped");
endtask
// A write while the clock enable is low must be lost; port B select is zero here
task automatic t_freeze();
	clk_en <= 1'b0;
	wr(`OFS_SEL_B, 16'hffff);
	clk_en <= 1'b1;
	rd(`OFS_SEL_B, 16'h0000, "frozen select");
	chk("frozen pin", 16'h0000, pin_is_analog[31:16]);
endtask
// Mid-run reset must bring back the analog and input defaults
task automatic t_rst2();
	hresetn <= 1'b0;
	repeat (2) @(posedge hclk);
	hresetn <= 1'b1;
	chk("select after reset", `MASK_SEL_B, pin_is_analog[31:16]);
	chk("direction after reset", 16'hffff, pin_is_input[31:16]);
	rd(`OFS_SEL_B, `MASK_SEL_B, "select read after reset");
	rd(`OFS_DIR_B, 16'hffff, "direction read after reset");
endtask
initial begin
	repeat (16) @(posedge hclk);
	hresetn <= 1'b1;
	t_reset();
	t_sel();
	t_dir();
	t_unmapped();
	t_freeze();
	t_rst2();
	stop_test();
end
endmodule
